// >>> i2c_status_addr_data_regs.sv
// Register side of the serial bus interface in two-wire mode, with an
// AXI4-Lite slave, the bit engine and a sticky event interrupt.
// Assumes open-drain pads resolved outside; one system clock domain.
// Function
// - Status and control two share one address: reads give status, writes go to control.
// - Status bits 7, 6, 5 show master role, direction, bus busy; upper bits zero.
// - Status bit 4 reads 0 while an interrupt is pending; resets to 1.
// - Bit 3 on arbitration loss, bit 1 on general call, bit 2 on match or call.
// - Status bit 0 shows the most recently received data line bit.
// - Idle register bit 6 chooses halt or run in low-power idle.
// - Idle register bits 7 and 5..1 read one; software writes bit 0 as zero.
// - Data buffer has separate transmit and receive storage; writes never read back.
// - Transmit data shifts out from bit 7; received bits fill from the low end.
// - Address register bits 7..1 hold the own address compared as slave.
// - Address register bit 0 selects address recognition or free-data format.
// - In free-data format a master transmits and a slave receives.
// - An all-zero own address matches the start byte 0x01; avoid it as slave.
// - The engine's byte-done pulse clears the pending bit, and the clock line is held low.
// - Any data buffer read or write sets the pending bit, releasing the clock.
// - Bus busy sets on a start condition and clears on a stop condition.
`timescale 1ns/1ps
module i2c_status_addr_data_regs
	import i2c_regs_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	input  wire logic [REG_AW-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [REG_AW-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              idle_req_i,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe_n_o,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_n_o,
	output logic                   serial_bus_irq_o
);

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              aw_got;
		logic              w_got;
		logic [REG_AW-1:0] awaddr;
		logic [7:0]        wdata;
		logic              wstrb0;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              master_role;
		logic              transmit_direction;
		logic              bus_busy;
		logic              pin;
		logic              arbitration_lost_flag;
		logic              own_address_hit;
		logic              general_call_hit;
		logic              idle_keep_running;
		logic              rate_bit0;
		logic [6:0]        slave_addr_field;
		logic              free_format_select;
		logic [7:0]        tx_byte;
		logic [NUM_EV-1:0] ev;
		logic [NUM_EV-1:0] ev_en;
		logic [1:0]        idle_s;
		logic              scl_oe_n;
		logic              sda_oe_n;
		logic              irq;
	} regs_s;

	regs_s st_r;
	regs_s st_nxt;

	logic [7:0] eng_rx;
	logic       eng_last;
	logic       eng_start;
	logic       eng_stop;
	logic       eng_done;
	logic       eng_hit;
	logic       eng_gcall;
	logic       eng_rw;
	logic       eng_al;
	logic       eng_sda_low;
	logic       eng_en;
	logic       trx_eff;
	logic [7:0] stat_byte;
	logic [7:0] idle_byte;

	// The engine halts in low-power idle unless told to keep running.
	assign eng_en = !(st_r.idle_s[1] && !st_r.idle_keep_running);
	assign trx_eff = st_r.free_format_select ? st_r.master_role
		: st_r.transmit_direction;
	assign stat_byte = {st_r.master_role, trx_eff, st_r.bus_busy, st_r.pin,
		st_r.arbitration_lost_flag, st_r.own_address_hit,
		st_r.general_call_hit, eng_last};
	assign idle_byte = IDLE_ONES | (8'(st_r.idle_keep_running) << IDLE_KEEP_BIT)
		| 8'(st_r.rate_bit0);

	i2c_bit_engine u_engine (
		.clk_sys_i  (clk_sys_i),
		.arst_n_i   (arst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.enable_i   (eng_en),
		.own_addr_i (st_r.slave_addr_field),
		.free_fmt_i (st_r.free_format_select),
		.master_i   (st_r.master_role),
		.trx_i      (st_r.transmit_direction),
		.tx_byte_i  (st_r.tx_byte),
		.rx_byte_o  (eng_rx),
		.last_bit_o (eng_last),
		.start_o    (eng_start),
		.stop_o     (eng_stop),
		.done_o     (eng_done),
		.hit_o      (eng_hit),
		.gcall_o    (eng_gcall),
		.rw_o       (eng_rw),
		.al_o       (eng_al),
		.sda_low_o  (eng_sda_low)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [NUM_EV-1:0] ev_set;
		logic [NUM_EV-1:0] ev_clr;
		logic [7:0]        ofs;
		ev_set = '0;
		ev_clr = '0;
		ofs = 8'h00;
		st_nxt = st_r;
		st_nxt.idle_s = {st_r.idle_s[0], idle_req_i};

		// Write address and data are taken in either order.
		if (s_axi_awvalid_i && st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata_i[7:0];
			st_nxt.wstrb0 = s_axi_wstrb_i[0];
		end
		if (st_r.bvalid && s_axi_bready_i) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			ofs = {st_r.awaddr[7:2], 2'b00};
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (ofs)
				OFS_DATA: begin
					if (st_r.wstrb0) begin
						st_nxt.tx_byte = st_r.wdata;
					end
					st_nxt.pin = 1'b1;
				end
				OFS_ADDR: begin
					if (st_r.wstrb0) begin
						st_nxt.slave_addr_field = st_r.wdata[7:1];
						st_nxt.free_format_select = st_r.wdata[0];
					end
				end
				OFS_STAT: begin
					if (st_r.wstrb0) begin
						st_nxt.master_role = st_r.wdata[ST_MASTER];
						st_nxt.transmit_direction = st_r.wdata[ST_TRX];
						if (st_r.wdata[ST_PIN]) begin
							st_nxt.pin = 1'b1;
						end
					end
				end
				OFS_IDLE: begin
					if (st_r.wstrb0) begin
						st_nxt.idle_keep_running = st_r.wdata[IDLE_KEEP_BIT];
						st_nxt.rate_bit0 = st_r.wdata[0];
					end
				end
				OFS_EVEN: begin
					if (st_r.wstrb0) begin
						st_nxt.ev_en = st_r.wdata[NUM_EV-1:0];
					end
				end
				OFS_EVCLR: begin
					if (st_r.wstrb0) begin
						ev_clr = st_r.wdata[NUM_EV-1:0];
					end
				end
				OFS_EVT: begin
					st_nxt.bresp = RESP_SLVERR;
				end
				default: begin
					st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

		// Read path: one read under way at a time.
		if (st_r.rvalid && s_axi_rready_i) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		if (s_axi_arvalid_i && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case ({s_axi_araddr_i[7:2], 2'b00})
				OFS_DATA: begin
					st_nxt.rdata = {24'h00_0000, eng_rx};
					st_nxt.pin = 1'b1;
				end
				OFS_ADDR: begin
					st_nxt.rdata = {24'h00_0000, st_r.slave_addr_field,
						st_r.free_format_select};
				end
				OFS_STAT: begin
					st_nxt.rdata = {24'h00_0000, stat_byte};
				end
				OFS_IDLE: begin
					st_nxt.rdata = {24'h00_0000, idle_byte};
				end
				OFS_EVT: begin
					st_nxt.rdata = {{(32-NUM_EV){1'b0}}, st_r.ev};
				end
				OFS_EVEN: begin
					st_nxt.rdata = {{(32-NUM_EV){1'b0}}, st_r.ev_en};
				end
				OFS_EVCLR: begin
					st_nxt.rdata = 32'h0000_0000;
				end
				default: begin
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Bus events are applied after software so that hardware wins.
		if (eng_start) begin
			st_nxt.bus_busy = 1'b1;
			st_nxt.own_address_hit = 1'b0;
			st_nxt.general_call_hit = 1'b0;
			st_nxt.arbitration_lost_flag = 1'b0;
		end
		if (eng_stop) begin
			st_nxt.bus_busy = 1'b0;
			st_nxt.master_role = 1'b0;
			st_nxt.transmit_direction = 1'b0;
			ev_set[EV_STOP] = 1'b1;
		end
		if (eng_al) begin
			st_nxt.arbitration_lost_flag = 1'b1;
			st_nxt.master_role = 1'b0;
			st_nxt.transmit_direction = 1'b0;
			ev_set[EV_AL] = 1'b1;
		end
		if (eng_hit) begin
			st_nxt.own_address_hit = 1'b1;
			st_nxt.general_call_hit = eng_gcall;
			st_nxt.transmit_direction = eng_rw;
			ev_set[EV_HIT] = 1'b1;
		end
		if (eng_done) begin
			st_nxt.pin = 1'b0;
			ev_set[EV_DONE] = 1'b1;
		end
		st_nxt.ev = (st_r.ev & ~ev_clr) | ev_set;
		st_nxt.irq = |(st_nxt.ev & st_nxt.ev_en);

		// Clock is held low while a request is pending and the engine is not halted.
		st_nxt.scl_oe_n = !(eng_en && !st_nxt.pin);
		st_nxt.sda_oe_n = !(eng_en && eng_sda_low);
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, pin: PIN_RST,
				slave_addr_field: ADDR_RST, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
				default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready_o = st_r.awready;
	assign s_axi_wready_o = st_r.wready;
	assign s_axi_bresp_o = st_r.bresp;
	assign s_axi_bvalid_o = st_r.bvalid;
	assign s_axi_arready_o = st_r.arready;
	assign s_axi_rdata_o = st_r.rdata;
	assign s_axi_rresp_o = st_r.rresp;
	assign s_axi_rvalid_o = st_r.rvalid;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n_o = st_r.scl_oe_n;
	assign sda_oe_n_o = st_r.sda_oe_n;
	assign serial_bus_irq_o = st_r.irq;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_wr_exec;
		st_r.aw_got && st_r.w_got && !st_r.bvalid;
	endsequence

	sequence s_data_wr;
		s_wr_exec ##0 ({st_r.awaddr[7:2], 2'b00} == OFS_DATA);
	endsequence

	sequence s_stat_rd;
		s_axi_arvalid_i && st_r.arready && ({s_axi_araddr_i[7:2], 2'b00} == OFS_STAT);
	endsequence

	a_status_read_word: assert property (s_stat_rd |=>
		s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h00_0000
		&& s_axi_rdata_o[ST_PIN] == $past(st_r.pin))
		else $error("status read word wrong");
	a_stat_write_steer: assert property ((s_wr_exec ##0 st_r.wstrb0 ##0
		({st_r.awaddr[7:2], 2'b00} == OFS_STAT) ##0 !eng_stop && !eng_al && !eng_hit)
		|=> st_r.master_role == $past(st_r.wdata[ST_MASTER]) && st_r.bvalid)
		else $error("status write not steered into control");
	a_done_clears_pin: assert property ((eng_done && eng_en) |=>
		!st_r.pin && !scl_oe_n_o)
		else $error("request did not clear pending bit and hold clock");
	a_pin_holds_scl: assert property ((!st_r.pin && $past(eng_en)) |-> !scl_oe_n_o)
		else $error("clock not held while pending");
	a_dbr_sets_pin: assert property ((s_data_wr ##0 !eng_done) |=> st_r.pin)
		else $error("data buffer write did not set pending bit");
	a_busy_follows: assert property ((eng_start |=> st_r.bus_busy)
		and (eng_stop |=> !st_r.bus_busy))
		else $error("bus busy does not follow start and stop");
	a_gcall_flags: assert property ((eng_gcall && !eng_start) |=>
		st_r.general_call_hit && st_r.own_address_hit)
		else $error("general call flags not set");
	a_al_flag: assert property (eng_al |=> st_r.arbitration_lost_flag && !st_r.master_role)
		else $error("arbitration loss not recorded");
	a_idle_ones: assert property ((s_axi_arvalid_i && st_r.arready
		&& {s_axi_araddr_i[7:2], 2'b00} == OFS_IDLE) |=>
		s_axi_rdata_o[7] && s_axi_rdata_o[5:1] == 5'h1f && s_axi_rdata_o[31:8] == 24'h0)
		else $error("idle register fixed bits wrong");
	a_free_direction: assert property ((s_stat_rd ##0 st_r.free_format_select) |=>
		s_axi_rdata_o[ST_TRX] == s_axi_rdata_o[ST_MASTER])
		else $error("free format direction not fixed by role");
	a_idle_halts: assert property ((st_r.idle_s[1] && !st_r.idle_keep_running)
		|=> scl_oe_n_o && sda_oe_n_o)
		else $error("interface not halted in idle");

endmodule // i2c_status_addr_data_regs

// >>> i2c_regs_pkg.sv
// Package for the serial bus register block: offsets, field positions,
// reset values, bit-counter values and the engine phase encoding.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package i2c_regs_pkg;

	localparam int REG_AW = 8;

	localparam logic [7:0] OFS_DATA  = 8'h00;
	localparam logic [7:0] OFS_ADDR  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_IDLE  = 8'h0c;
	localparam logic [7:0] OFS_EVT   = 8'h10;
	localparam logic [7:0] OFS_EVEN  = 8'h14;
	localparam logic [7:0] OFS_EVCLR = 8'h18;

	localparam int ST_MASTER = 7;
	localparam int ST_TRX    = 6;
	localparam int ST_PIN    = 4;
	localparam int IDLE_KEEP_BIT = 6;
	localparam logic [7:0] IDLE_ONES = 8'hbe;

	localparam int NUM_EV  = 4;
	localparam int EV_DONE = 0;
	localparam int EV_AL   = 1;
	localparam int EV_HIT  = 2;
	localparam int EV_STOP = 3;

	localparam logic       PIN_RST  = 1'b1;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] GCALL_BYTE = 8'h00;

	localparam logic [3:0] CNT_PRE  = 4'hf;
	localparam logic [3:0] CNT_LAST = 4'h7;
	localparam logic [3:0] CNT_ACK  = 4'h8;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b11,
		PH_SKIP = 2'b10
	} ph_e;

endpackage

// >>> i2c_bit_engine.sv
// Bit engine: synchronises the bus lines, detects start and stop, counts
// bits and acknowledge, recognises addresses and shifts bytes in and out.
// Assumes raw open-drain pin levels on scl_i and sda_i.
`timescale 1ns/1ps
module i2c_bit_engine
	import i2c_regs_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       arst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       enable_i,
	input  wire logic [6:0] own_addr_i,
	input  wire logic       free_fmt_i,
	input  wire logic       master_i,
	input  wire logic       trx_i,
	input  wire logic [7:0] tx_byte_i,
	output logic      [7:0] rx_byte_o,
	output logic            last_bit_o,
	output logic            start_o,
	output logic            stop_o,
	output logic            done_o,
	output logic            hit_o,
	output logic            gcall_o,
	output logic            rw_o,
	output logic            al_o,
	output logic            sda_low_o
);

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_d;
		logic       sda_d;
		ph_e        ph;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] rx;
		logic       last_bit;
		logic       drive_low;
		logic       start;
		logic       stop;
		logic       done;
		logic       hit;
		logic       gcall;
		logic       rw;
		logic       al;
	} eng_s;

	eng_s r;
	eng_s n;

	always_comb begin
		logic scl;
		logic sda;
		logic xmit;
		logic tx_on;
		logic [7:0] b;
		scl = r.scl_s[1];
		sda = r.sda_s[1];
		b = {r.sh[6:0], sda};
		xmit = free_fmt_i ? master_i : trx_i;
		tx_on = xmit && (master_i || r.ph == PH_DATA);
		n = r;
		n.start = 1'b0;
		n.stop = 1'b0;
		n.done = 1'b0;
		n.hit = 1'b0;
		n.gcall = 1'b0;
		n.al = 1'b0;
		n.scl_s = {r.scl_s[0], scl_i};
		n.sda_s = {r.sda_s[0], sda_i};
		n.scl_d = scl;
		n.sda_d = sda;
		if (!enable_i) begin
			n.ph = PH_IDLE;
			n.cnt = CNT_PRE;
			n.drive_low = 1'b0;
		end else if (scl && r.sda_d && !sda) begin
			n.start = 1'b1;
			n.ph = free_fmt_i ? PH_DATA : PH_ADDR;
			n.cnt = CNT_PRE;
			n.tx = tx_byte_i;
			n.drive_low = 1'b0;
		end else if (scl && !r.sda_d && sda) begin
			n.stop = 1'b1;
			n.ph = PH_IDLE;
			n.drive_low = 1'b0;
		end else if (r.ph != PH_IDLE) begin
			if (scl && !r.scl_d) begin
				if (r.cnt <= CNT_ACK) begin
					n.last_bit = sda;
				end
				if (r.cnt < CNT_ACK) begin
					n.sh = b;
					if (tx_on && r.tx[7] && !sda) begin
						n.al = master_i;
						n.ph = PH_SKIP;
					end
				end
				if (r.cnt == CNT_LAST && n.ph != PH_SKIP) begin
					n.rx = b;
					if (r.ph == PH_ADDR && !master_i) begin
						if (b == GCALL_BYTE) begin
							n.gcall = 1'b1;
							n.hit = 1'b1;
							n.rw = 1'b0;
							n.ph = PH_DATA;
						end else if (b[7:1] == own_addr_i) begin
							n.hit = 1'b1;
							n.rw = b[0];
							n.ph = PH_DATA;
						end else begin
							n.ph = PH_SKIP;
						end
					end else if (r.ph == PH_ADDR) begin
						n.ph = PH_DATA;
					end
				end
			end else if (!scl && r.scl_d) begin
				if (r.cnt == CNT_PRE) begin
					n.cnt = 4'h0;
				end else if (r.cnt == CNT_ACK) begin
					n.cnt = 4'h0;
					n.done = master_i || r.ph == PH_DATA;
					n.tx = tx_byte_i;
				end else begin
					n.cnt = r.cnt + 4'h1;
					n.tx = {r.tx[6:0], 1'b1};
				end
				if (n.ph == PH_SKIP) begin
					n.drive_low = 1'b0;
				end else if (n.cnt == CNT_ACK) begin
					n.drive_low = !tx_on && (master_i || n.ph == PH_DATA);
				end else begin
					n.drive_low = tx_on && !n.tx[7];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r <= '{scl_s: 2'b11, sda_s: 2'b11, scl_d: 1'b1, sda_d: 1'b1,
				ph: PH_IDLE, cnt: CNT_PRE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign rx_byte_o = r.rx;
	assign last_bit_o = r.last_bit;
	assign start_o = r.start;
	assign stop_o = r.stop;
	assign done_o = r.done;
	assign hit_o = r.hit;
	assign gcall_o = r.gcall;
	assign rw_o = r.rw;
	assign al_o = r.al;
	assign sda_low_o = r.drive_low;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	a_gcall_also_hit: assert property (gcall_o |-> hit_o && !rw_o)
		else $error("general call without address hit");
	a_zero_addr_start: assert property (
		(own_addr_i == 7'h00 && !master_i && r.ph == PH_ADDR && r.cnt == CNT_LAST
		&& r.scl_s[1] && !r.scl_d && r.sh[6:0] == 7'h00 && r.sda_s[1]
		&& enable_i) |=> hit_o)
		else $error("start byte not matched with zero own address");

endmodule // i2c_bit_engine

// >>> i2c_peer_model.sv
// Peer model: a master on the two-wire bus with open-drain drive outputs.
// Assumes the bench resolves both wired-AND lines with pull-ups.
`timescale 1ns/1ps
module i2c_peer_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_drv_o,
	output logic      sda_drv_o
);
	localparam int HALF = 12;
	initial begin
		scl_drv_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	////////////////////////////////////////
	task automatic pause();
		repeat (HALF) @(posedge clk_i);
	endtask
	// Waits while the slave stretches the clock, then samples data at the end of the high phase.
	task automatic clk_high(output logic smp);
		int n;
		scl_drv_o <= 1'b1;
		@(posedge clk_i);
		for (n = 0; n < 3000 && scl_i !== 1'b1; n++) begin
			@(posedge clk_i);
		end
		if (n == 3000) tb.hang();
		pause();
		smp = sda_i;
	endtask
	task automatic start_cond();
		sda_drv_o <= 1'b0;
		pause();
		scl_drv_o <= 1'b0;
		pause();
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic smp;
		for (int i = 7; i >= 0; i--) begin
			sda_drv_o <= d[i];
			pause();
			clk_high(smp);
			scl_drv_o <= 1'b0;
			pause();
		end
		sda_drv_o <= 1'b1;
		pause();
		clk_high(ack);
		scl_drv_o <= 1'b0;
		pause();
	endtask
	task automatic stop_cond();
		logic smp;
		sda_drv_o <= 1'b0;
		pause();
		clk_high(smp);
		sda_drv_o <= 1'b1;
		pause();
	endtask
endmodule // i2c_peer_model

// >>> tb.sv
// Self-checking bench for the serial bus register block.
// Assumes the peer model as bus master and pull-ups on both lines.
`timescale 1ns/1ps
module tb
	import i2c_regs_pkg::*;
;
	logic        clk      = 1'b0;
	logic        rst_n    = 1'b0;
	logic        idle_req = 1'b0;
	logic        awv      = 1'b0;
	logic        wv       = 1'b0;
	logic        bready   = 1'b0;
	logic        arv      = 1'b0;
	logic        rready   = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic [7:0]  araddr   = 8'h00;
	logic [31:0] wdata    = 32'h0;
	logic [3:0]  wstrb    = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, ack;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, irq, scl_m, sda_m;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rd_v;
	logic [31:0] mdl [8];
	logic [6:0]  own;
	logic [7:0]  dbyte;
	logic [7:0]  rst_ofs [5] = '{OFS_STAT, OFS_IDLE, OFS_ADDR, OFS_EVT, OFS_EVEN};
	logic [31:0] rst_val [5] = '{32'h10, 32'hbe, 32'h0, 32'h0, 32'h0};
	int          n_errors = 0;
	int          checked  = 0;
	wire         scl_w    = scl_m & (scl_oe_n | scl_o);
	wire         sda_w    = sda_m & (sda_oe_n | sda_o);
	always #10 clk = ~clk;
	i2c_peer_model i_peer (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
		.scl_drv_o(scl_m), .sda_drv_o(sda_m));
	i2c_status_addr_data_regs i_dut (.clk_sys_i(clk), .arst_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .idle_req_i(idle_req),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .serial_bus_irq_o(irq));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string s);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, s, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		n_errors++;
		$display("mismatch at %0t: wait timed out", $time);
		complete_run();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 100) hang();
		// Writable bits only; the idle register keeps its fixed ones.
		if (r === RESP_OKAY)
			mdl[a[4:2]] = (a == OFS_IDLE) ? (32'hbe | (d & 32'h41)) : (d & 32'hff);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arv && arready) arv <= 1'b0;
			if (rvalid === 1'b1) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 100) hang();
	endtask
	task automatic wrk(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rsp);
		check(32'(rsp), 32'(RESP_OKAY), "write response");
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, string s);
		rd(a, rd_v, rsp);
		check(rd_v & m, e, s);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		hang();
	end
	initial begin
		rd_v = $urandom(95179);
		own = 7'(($urandom % 126) + 1);
		dbyte = 8'($urandom);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rst_ofs[i]) rdc(rst_ofs[i], 32'hffffffff, rst_val[i], "reset value");
		rd(8'h1c, rd_v, rsp);
		check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
		wr(OFS_EVT, 32'hff, rsp);
		check(32'(rsp), 32'(RESP_SLVERR), "read-only write");
		wrk(OFS_IDLE, 32'h40);
		rdc(OFS_IDLE, 32'hffffffff, mdl[3], "idle option");
		wrk(OFS_ADDR, {24'h0, own, 1'b1});
		rdc(OFS_ADDR, 32'hffffffff, mdl[1], "free format");
		wrk(OFS_ADDR, {24'h0, own, 1'b0});
		rdc(OFS_ADDR, 32'hffffffff, mdl[1], "own address");
		wrk(OFS_DATA, {24'h0, ~dbyte});
		rdc(OFS_DATA, 32'hffffffff, 32'h0, "no readback");
		wrk(OFS_EVEN, 32'h1);
		i_peer.start_cond();
		rdc(OFS_STAT, 32'hffffffff, 32'h30, "busy");
		i_peer.send_byte({own, 1'b0}, ack);
		check(32'(ack), 32'h0, "address ack");
		repeat (8) @(posedge clk);
		check(32'(scl_oe_n), 32'h0, "clock held");
		check(32'(irq), 32'h1, "irq raised");
		rdc(OFS_STAT, 32'hfe, 32'h24, "addressed");
		wrk(OFS_EVEN, 32'h0);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0, "irq masked");
		rdc(OFS_EVT, 32'hffffffff, 32'h5, "events");
		wrk(OFS_EVCLR, 32'h5);
		rdc(OFS_EVT, 32'hffffffff, 32'h0, "events cleared");
		rd(OFS_DATA, rd_v, rsp);
		repeat (8) @(posedge clk);
		check(32'(scl_oe_n), 32'h1, "clock released");
		rdc(OFS_STAT, 32'h10, 32'h10, "pending cleared");
		i_peer.send_byte(dbyte, ack);
		rdc(OFS_DATA, 32'hffffffff, {24'h0, dbyte}, "received byte");
		i_peer.stop_cond();
		rdc(OFS_STAT, 32'h20, 32'h0, "bus free");
		i_peer.start_cond();
		i_peer.send_byte(8'h00, ack);
		rdc(OFS_STAT, 32'hfe, 32'h26, "general call");
		rd(OFS_DATA, rd_v, rsp);
		i_peer.stop_cond();
		wrk(OFS_ADDR, {24'h0, own, 1'b1});
		i_peer.start_cond();
		i_peer.send_byte(dbyte, ack);
		rdc(OFS_STAT, 32'he4, 32'h20, "free format roles");
		rdc(OFS_DATA, 32'hffffffff, {24'h0, dbyte}, "free data");
		i_peer.stop_cond();
		wrk(OFS_DATA, 32'hff);
		wrk(OFS_ADDR, 32'h0);
		i_peer.start_cond();
		i_peer.send_byte(8'h01, ack);
		rdc(OFS_STAT, 32'hfe, 32'h64, "start byte match");
		rdc(OFS_DATA, 32'hffffffff, 32'h01, "start byte");
		i_peer.stop_cond();
		wrk(OFS_ADDR, {24'h0, own, 1'b0});
		wrk(OFS_STAT, 32'hc0);
		rdc(OFS_STAT, 32'hf0, 32'hd0, "control two steered");
		i_peer.start_cond();
		i_peer.send_byte(8'h00, ack);
		rdc(OFS_STAT, 32'hff, 32'h39, "arbitration lost");
		i_peer.stop_cond();
		rdc(OFS_EVT, 32'h2, 32'h2, "lost event");
		idle_req <= 1'b1;
		repeat (4) @(posedge clk);
		i_peer.start_cond();
		i_peer.send_byte({own, 1'b0}, ack);
		check(32'(ack), 32'h0, "running in idle");
		rd(OFS_DATA, rd_v, rsp);
		i_peer.stop_cond();
		wrk(OFS_IDLE, 32'h0);
		i_peer.start_cond();
		i_peer.send_byte({own, 1'b0}, ack);
		check(32'(ack), 32'h1, "halted in idle");
		i_peer.stop_cond();
		idle_req <= 1'b0;
		complete_run();
	end
endmodule // tb
